// *** logic/ucpd_pkg.sv ***
// Constants, register map and carriers for the UART pin and PC decode block
//
// Overview of operation
// - Falling address enable validates selected COM address
// - IRQ output enabled by control bit 3, enables
// - Three IRQ outputs active high, tri-state
// - PC mode drives two active-low printer decodes
// - PC mode routes baud tick to receiver clock
// - Transmit idles high normally, low in infrared
// - Infrared mode by strap pin or software
// - Receive idle is 1 normally, 0 infrared
// - Infrared pulses pass a decoder before receiver
// - Far side holds receive idle; else break flagged
// - Auto RTS via feature bit 6, control bit 1
// - RTS as RS-485 direction via extra bits 2,5
// - Auto CTS stops transmit while CTS deasserted
// - DSR, CD, RI inputs active low, general use
// - DTR output active low, general use
// - Strap sampled at reset release, then software
package ucpd_pkg;

	// Register byte offsets on the APB
	localparam logic [7:0] OFS_MODEM_CTRL   = 8'h00;
	localparam logic [7:0] OFS_INT_ENABLE   = 8'h04;
	localparam logic [7:0] OFS_ENH_FEATURE  = 8'h08;
	localparam logic [7:0] OFS_EXTRA_FEAT   = 8'h0C;
	localparam logic [7:0] OFS_PIN_STATUS   = 8'h10;

	// Reset values
	localparam logic [7:0] RST_MODEM_CTRL   = 8'h00;
	localparam logic [7:0] RST_INT_ENABLE   = 8'h00;
	localparam logic [7:0] RST_ENH_FEATURE  = 8'h00;
	localparam logic [7:0] RST_EXTRA_FEAT   = 8'h00;

	// Field positions
	localparam int MCR_DTR      = 0;
	localparam int MCR_RTS      = 1;
	localparam int MCR_IRQ_EN   = 3;
	localparam int MCR_IR_MODE  = 6;
	localparam int IER_RTS_CHG  = 6;
	localparam int IER_CTS_CHG  = 7;
	localparam int EFR_AUTO_RTS = 6;
	localparam int EFR_AUTO_CTS = 7;
	localparam int XFR_RS485    = 2;
	localparam int XFR_RS485_HI = 5;
	localparam int ST_DSR       = 0;
	localparam int ST_CD        = 1;
	localparam int ST_RI        = 2;
	localparam int ST_CTS       = 3;
	localparam int ST_IR        = 4;
	localparam int ST_PC        = 5;
	localparam int ST_COM_OK    = 6;
	localparam int ST_BREAK     = 8;
	localparam int ST_CTS_CHG   = 9;
	localparam int ST_RTS_CHG   = 10;

	// Cycle counts
	localparam int SYNC_STAGES      = 2;
	localparam int STRAP_WAIT       = 2;
	localparam int BREAK_CYCLES     = 160;
	localparam int IR_STRETCH_CYCLES = 16;

	// Address decode: COM bases, printer bases, 8-byte windows
	localparam int ADDR_W = 10;
	localparam logic [3:0][9:0] COM_BASE = {10'h2E8, 10'h3E8, 10'h2F8, 10'h3F8};
	localparam logic [9:0] PRINTER1_DECODE_N_BASE = 10'h378;
	localparam logic [9:0] PRINTER2_DECODE_N_BASE = 10'h278;
	// Port select setting to COM index and IRQ line (0 A, 1 B, 2 C)
	localparam logic [7:0][1:0] SEL_COM = {2'h3, 2'h2, 2'h1, 2'h0,
		2'h3, 2'h2, 2'h1, 2'h0};
	localparam logic [7:0][1:0] SEL_IRQ = {2'h2, 2'h2, 2'h1, 2'h1,
		2'h1, 2'h0, 2'h1, 2'h0};

	// Modem status pins, already active high after inversion
	typedef struct packed {
		logic dsr;
		logic cd;
		logic ri;
		logic cts;
	} ucpd_modem_s;

	// Three-state interrupt request group
	typedef struct packed {
		logic [2:0] level;
		logic [2:0] oe;
	} ucpd_irq_s;

endpackage : ucpd_pkg

// *** logic/ucpd_ir_decode.sv ***
// Infrared pulse decoder: stretches each short high pulse into a low bit
`timescale 1ns/10ps
module ucpd_ir_decode #(
	parameter int STRETCH = ucpd_pkg::IR_STRETCH_CYCLES
) (
	input  wire logic clk_sys,
	input  wire logic rst_b,
	input  wire logic ir_in,
	output logic      rx_bit
);
	// The stretch counter is 16 bits; refuse lengths it cannot hold
	if (STRETCH < 1 || STRETCH > 65535)
	begin : g_bad_stretch
		$error("STRETCH out of range");
	end

	logic [15:0] cnt_q;
	logic [15:0] cnt_d;
	logic        prev_q;
	logic        prev_d;
	logic        bit_q;
	logic        bit_d;

	// A rising pulse restarts the low stretch; idle pulses never reach rx
	always_comb
	begin
		prev_d = ir_in;
		cnt_d  = cnt_q;
		bit_d  = 1'b1;
		if (ir_in && !prev_q)
			cnt_d = 16'(STRETCH);
		else if (cnt_q != 16'h0000)
			cnt_d = cnt_q - 16'h0001;
		if (cnt_d != 16'h0000)
			bit_d = 1'b0;
	end

	always_ff @(posedge clk_sys or negedge rst_b)
	begin
		if (!rst_b)
		begin
			cnt_q  <= 16'h0000;
			prev_q <= 1'b0;
			bit_q  <= 1'b1;
		end
		else
		begin
			cnt_q  <= cnt_d;
			prev_q <= prev_d;
			bit_q  <= bit_d;
		end
	end

	assign rx_bit = bit_q;
endmodule : ucpd_ir_decode

// *** logic/ucpd_top.sv ***
// Pin-level UART glue: PC decode, IRQ lines, serial polarity, flow control
`timescale 1ns/10ps
module ucpd_top (
	input  wire logic        clk_sys,
	input  wire logic        rst_b,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [7:0]  paddr,
	input  wire logic [31:0] pwdata,
	output logic [31:0]      prdata,
	output logic             pready,
	output logic             pslverr,
	input  wire logic [9:0]  host_addr,
	input  wire logic        address_enable_n,
	input  wire logic        port_select_1,
	input  wire logic        port_select_2,
	input  wire logic        port_select_3,
	input  wire logic        pc_decode_select_n,
	input  wire logic        bus_style_select,
	output ucpd_pkg::ucpd_irq_s isa_irq,
	output logic             com_select,
	output logic             printer1_decode_n,
	output logic             printer2_decode_n,
	output logic             baud_gen_clock_out_n,
	input  wire logic        baud_tick,
	input  wire logic        rclk_pin,
	output logic             rx_clk_tick,
	input  wire logic [3:0]  core_int_pending,
	input  wire logic        tx_core_bit,
	input  wire logic        tx_busy,
	input  wire logic        rx_room,
	output logic             tx_hold,
	output logic             rx_core_bit,
	output logic             tx_pin,
	input  wire logic        rx_pin,
	input  wire logic        infrared_enable_pin,
	output logic             rts_n,
	input  wire logic        cts_n,
	output logic             dtr_n,
	input  wire logic        dsr_n,
	input  wire logic        cd_n,
	input  wire logic        ri_n
);
	localparam int SW = 23;

	// Two-stage synchroniser for every pin input; stage 1 feeds stage 2 only
	logic [SW-1:0] sync1_q;
	logic [SW-1:0] sync2_q;
	always_ff @(posedge clk_sys or negedge rst_b)
	begin
		if (!rst_b)
		begin
			sync1_q <= {SW{1'b1}};
			sync2_q <= {SW{1'b1}};
		end
		else
		begin
			sync1_q <= {host_addr, address_enable_n, port_select_1,
				port_select_2, port_select_3, pc_decode_select_n,
				bus_style_select, rclk_pin, rx_pin, infrared_enable_pin,
				dsr_n, cd_n, ri_n, cts_n};
			sync2_q <= sync1_q;
		end
	end

	logic [9:0] addr_s;
	logic       aen_n_s;
	logic [2:0] sel_s;
	logic       pcsel_n_s;
	logic       bus_s;
	logic       rclk_s;
	logic       rx_s;
	logic       ir_strap_s;
	ucpd_pkg::ucpd_modem_s modem_s;
	assign {addr_s, aen_n_s, sel_s, pcsel_n_s, bus_s, rclk_s, rx_s,
		ir_strap_s} = sync2_q[SW-1:4];
	// Modem pins are active low; status holds them active high
	assign modem_s = ~sync2_q[3:0];

	// Register state and derived modes
	logic [7:0]  mcr_q;
	logic [7:0]  mcr_d;
	logic [7:0]  ier_q;
	logic [7:0]  ier_d;
	logic [7:0]  efr_q;
	logic [7:0]  efr_d;
	logic [7:0]  xfr_q;
	logic [7:0]  xfr_d;
	logic [2:0]  sticky_q;
	logic [2:0]  sticky_d;
	logic [1:0]  strap_cnt_q;
	logic [1:0]  strap_cnt_d;
	logic        com_ok_q;
	logic        pc_mode;
	logic        ir_mode;
	logic        wr_en;
	logic        rd_hit;
	logic        brk_evt;
	logic        cts_evt;
	logic        rts_evt;

	assign pc_mode = !pcsel_n_s && !bus_s;
	assign ir_mode = mcr_q[ucpd_pkg::MCR_IR_MODE];

	// APB slave: zero wait states, error on unmapped offsets
	assign pready = 1'b1;
	assign wr_en  = psel && penable && pwrite;
	always_comb
	begin
		rd_hit = 1'b1;
		case (paddr)
			ucpd_pkg::OFS_MODEM_CTRL:  prdata = {24'h000000, mcr_q};
			ucpd_pkg::OFS_INT_ENABLE:  prdata = {24'h000000, ier_q};
			ucpd_pkg::OFS_ENH_FEATURE: prdata = {24'h000000, efr_q};
			ucpd_pkg::OFS_EXTRA_FEAT:  prdata = {24'h000000, xfr_q};
			ucpd_pkg::OFS_PIN_STATUS:  prdata = {21'h000000, sticky_q,
				1'b0, com_ok_q, pc_mode, ir_mode, modem_s.cts,
				modem_s.ri, modem_s.cd, modem_s.dsr};
			default:
			begin
				prdata = 32'h00000000;
				rd_hit = 1'b0;
			end
		endcase
		pslverr = psel && penable && !rd_hit;
	end

	// Register next values; strap loads infrared bit once after release
	always_comb
	begin
		mcr_d = mcr_q;
		ier_d = ier_q;
		efr_d = efr_q;
		xfr_d = xfr_q;
		strap_cnt_d = strap_cnt_q;
		if (strap_cnt_q != 2'(ucpd_pkg::STRAP_WAIT + 1))
			strap_cnt_d = strap_cnt_q + 2'h1;
		if (strap_cnt_q == 2'(ucpd_pkg::STRAP_WAIT))
			mcr_d[ucpd_pkg::MCR_IR_MODE] = ir_strap_s;
		if (wr_en)
		begin
			case (paddr)
				ucpd_pkg::OFS_MODEM_CTRL:  mcr_d = pwdata[7:0];
				ucpd_pkg::OFS_INT_ENABLE:  ier_d = pwdata[7:0];
				ucpd_pkg::OFS_ENH_FEATURE: efr_d = pwdata[7:0];
				ucpd_pkg::OFS_EXTRA_FEAT:  xfr_d = pwdata[7:0];
				default: ;
			endcase
		end
		// Events set after a write-one clear so a same-cycle event survives
		sticky_d = sticky_q;
		if (wr_en && paddr == ucpd_pkg::OFS_PIN_STATUS)
			sticky_d = sticky_q & ~pwdata[ucpd_pkg::ST_RTS_CHG:
				ucpd_pkg::ST_BREAK];
		sticky_d = sticky_d | {rts_evt, cts_evt, brk_evt};
	end

	always_ff @(posedge clk_sys or negedge rst_b)
	begin
		if (!rst_b)
		begin
			mcr_q       <= ucpd_pkg::RST_MODEM_CTRL;
			ier_q       <= ucpd_pkg::RST_INT_ENABLE;
			efr_q       <= ucpd_pkg::RST_ENH_FEATURE;
			xfr_q       <= ucpd_pkg::RST_EXTRA_FEAT;
			sticky_q    <= 3'h0;
			strap_cnt_q <= 2'h0;
		end
		else
		begin
			mcr_q       <= mcr_d;
			ier_q       <= ier_d;
			efr_q       <= efr_d;
			xfr_q       <= xfr_d;
			sticky_q    <= sticky_d;
			strap_cnt_q <= strap_cnt_d;
		end
	end

	// PC address decode, interrupt steering and printer decodes
	logic       aen_prev_q;
	logic       com_ok_d;
	logic       com_sel_q;
	logic       com_sel_d;
	logic       printer1_decode_n_n_q;
	logic       printer1_decode_n_n_d;
	logic       printer2_decode_n_n_q;
	logic       printer2_decode_n_n_d;
	logic       com_match;
	logic [1:0] irq_idx;
	logic       irq_level;
	ucpd_pkg::ucpd_irq_s irq_d;
	ucpd_pkg::ucpd_irq_s irq_q;

	assign irq_idx   = ucpd_pkg::SEL_IRQ[sel_s];
	assign com_match = addr_s[9:3] ==
		ucpd_pkg::COM_BASE[ucpd_pkg::SEL_COM[sel_s]][9:3];
	assign irq_level = |(core_int_pending & ier_q[3:0])
		|| (ier_q[ucpd_pkg::IER_RTS_CHG] && sticky_q[2])
		|| (ier_q[ucpd_pkg::IER_CTS_CHG] && sticky_q[1]);

	always_comb
	begin
		// Validation is latched on the enable falling edge, held while low
		com_ok_d = com_ok_q;
		if (aen_n_s)
			com_ok_d = 1'b0;
		else if (aen_prev_q)
			com_ok_d = pc_mode && com_match;
		com_sel_d = com_ok_d && !aen_n_s && com_match;
		printer1_decode_n_n_d = !(pc_mode && !aen_n_s
			&& addr_s[9:3] == ucpd_pkg::PRINTER1_DECODE_N_BASE[9:3]);
		printer2_decode_n_n_d = !(pc_mode && !aen_n_s
			&& addr_s[9:3] == ucpd_pkg::PRINTER2_DECODE_N_BASE[9:3]);
		// Only the strapped line drives; the others float on the bus
		irq_d.oe    = 3'h0;
		irq_d.level = 3'h0;
		if (pc_mode && mcr_q[ucpd_pkg::MCR_IRQ_EN] && irq_idx != 2'h3)
		begin
			irq_d.oe[irq_idx]    = 1'b1;
			irq_d.level[irq_idx] = irq_level;
		end
	end

	always_ff @(posedge clk_sys or negedge rst_b)
	begin
		if (!rst_b)
		begin
			aen_prev_q <= 1'b1;
			com_ok_q   <= 1'b0;
			com_sel_q  <= 1'b0;
			printer1_decode_n_n_q   <= 1'b1;
			printer2_decode_n_n_q   <= 1'b1;
			irq_q      <= '0;
		end
		else
		begin
			aen_prev_q <= aen_n_s;
			com_ok_q   <= com_ok_d;
			com_sel_q  <= com_sel_d;
			printer1_decode_n_n_q   <= printer1_decode_n_n_d;
			printer2_decode_n_n_q   <= printer2_decode_n_n_d;
			irq_q      <= irq_d;
		end
	end

	assign isa_irq           = irq_q;
	assign com_select        = com_sel_q;
	assign printer1_decode_n = printer1_decode_n_n_q;
	assign printer2_decode_n = printer2_decode_n_n_q;

	// Infrared path: decoded pulses replace the raw receive level
	logic ir_rx_bit;
	ucpd_ir_decode #(
		.STRETCH (ucpd_pkg::IR_STRETCH_CYCLES)
	) u_ir_decode (
		.clk_sys (clk_sys),
		.rst_b   (rst_b),
		.ir_in   (rx_s && ir_mode),
		.rx_bit  (ir_rx_bit)
	);

	// Serial lines, clock routing, flow control and break watch
	logic        rclk_prev_q;
	logic        rx_q;
	logic        rx_d;
	logic        tx_q;
	logic        tx_d;
	logic        baud_q;
	logic        baud_d;
	logic        tick_q;
	logic        tick_d;
	logic        rts_n_q;
	logic        rts_n_d;
	logic        dtr_n_q;
	logic        hold_q;
	logic        hold_d;
	logic        cts_prev_q;
	logic [7:0]  brk_cnt_q;
	logic [7:0]  brk_cnt_d;

	assign cts_evt = modem_s.cts != cts_prev_q;
	assign rts_evt = rts_n_d != rts_n_q;
	assign brk_evt = brk_cnt_q == 8'(ucpd_pkg::BREAK_CYCLES - 1) && !rx_d;

	always_comb
	begin
		rx_d = ir_mode ? ir_rx_bit : rx_s;
		// Core bit 1 is idle; infrared sends a high pulse for a 0 bit
		tx_d = ir_mode ? !tx_core_bit : tx_core_bit;
		baud_d = pc_mode ? printer1_decode_n_n_d : !baud_tick;
		tick_d = pc_mode ? baud_tick : (rclk_s && !rclk_prev_q);
		hold_d = efr_q[ucpd_pkg::EFR_AUTO_CTS] && !modem_s.cts;
		// Direction control wins over automatic flow, which needs MODEM_CONTROL_REG RTS
		if (xfr_q[ucpd_pkg::XFR_RS485])
			rts_n_d = !(tx_busy ^ !xfr_q[ucpd_pkg::XFR_RS485_HI]);
		else if (efr_q[ucpd_pkg::EFR_AUTO_RTS])
			rts_n_d = !(mcr_q[ucpd_pkg::MCR_RTS] && rx_room);
		else
			rts_n_d = !mcr_q[ucpd_pkg::MCR_RTS];
		// Counter saturates so a stuck line flags once until receive goes high again
		brk_cnt_d = 8'h00;
		if (!rx_d && brk_cnt_q != 8'(ucpd_pkg::BREAK_CYCLES))
			brk_cnt_d = brk_cnt_q + 8'h01;
		else if (!rx_d)
			brk_cnt_d = brk_cnt_q;
	end

	always_ff @(posedge clk_sys or negedge rst_b)
	begin
		if (!rst_b)
		begin
			rclk_prev_q <= 1'b1;
			rx_q        <= 1'b1;
			tx_q        <= 1'b1;
			baud_q      <= 1'b1;
			tick_q      <= 1'b0;
			rts_n_q     <= 1'b1;
			dtr_n_q     <= 1'b1;
			hold_q      <= 1'b0;
			cts_prev_q  <= 1'b0;
			brk_cnt_q   <= 8'h00;
		end
		else
		begin
			rclk_prev_q <= rclk_s;
			rx_q        <= rx_d;
			tx_q        <= tx_d;
			baud_q      <= baud_d;
			tick_q      <= tick_d;
			rts_n_q     <= rts_n_d;
			dtr_n_q     <= !mcr_q[ucpd_pkg::MCR_DTR];
			hold_q      <= hold_d;
			cts_prev_q  <= modem_s.cts;
			brk_cnt_q   <= brk_cnt_d;
		end
	end

	assign rx_core_bit          = rx_q;
	assign tx_pin               = tx_q;
	assign baud_gen_clock_out_n = baud_q;
	assign rx_clk_tick          = tick_q;
	assign rts_n                = rts_n_q;
	assign dtr_n                = dtr_n_q;
	assign tx_hold              = hold_q;

	// Checks on the decode, IRQ, polarity and flow control logic
	sequence s_aen_fall;
		$fell(aen_n_s) ##0 pc_mode && com_match;
	endsequence

	AST_COM_VALID: assert property (@(posedge clk_sys) disable iff (!rst_b)
		s_aen_fall |=> com_ok_q) else $error("COM not validated");
	AST_IRQ_OFF: assert property (@(posedge clk_sys) disable iff (!rst_b)
		!$past(mcr_q[ucpd_pkg::MCR_IRQ_EN]) |-> isa_irq.oe == 3'h0)
		else $error("IRQ driven while disabled");
	AST_IRQ_ONEHOT: assert property (@(posedge clk_sys) disable iff (!rst_b)
		$onehot0(isa_irq.oe) && (isa_irq.level & ~isa_irq.oe) == 3'h0)
		else $error("IRQ drive not single line");
	AST_LPT_IDLE: assert property (@(posedge clk_sys) disable iff (!rst_b)
		!$past(pc_mode) |-> printer1_decode_n && printer2_decode_n)
		else $error("Printer decode outside PC mode");
	AST_TX_POL: assert property (@(posedge clk_sys) disable iff (!rst_b)
		$past(rst_b) |-> tx_pin == ($past(ir_mode) ^ $past(tx_core_bit)))
		else $error("Transmit polarity wrong");
	AST_RX_TICK: assert property (@(posedge clk_sys) disable iff (!rst_b)
		pc_mode && baud_tick |=> rx_clk_tick)
		else $error("Baud tick not routed");
	AST_CTS_HOLD: assert property (@(posedge clk_sys) disable iff (!rst_b)
		efr_q[ucpd_pkg::EFR_AUTO_CTS] && !modem_s.cts |=> tx_hold)
		else $error("Transmit not held on CTS");
	AST_RTS_MAN: assert property (@(posedge clk_sys) disable iff (!rst_b)
		!xfr_q[ucpd_pkg::XFR_RS485] && !efr_q[ucpd_pkg::EFR_AUTO_RTS]
		&& !mcr_q[ucpd_pkg::MCR_RTS] |=> rts_n)
		else $error("RTS asserted without control bit");
	AST_RS485: assert property (@(posedge clk_sys) disable iff (!rst_b)
		xfr_q[ucpd_pkg::XFR_RS485] && xfr_q[ucpd_pkg::XFR_RS485_HI]
		&& tx_busy |=> !rts_n) else $error("RS-485 direction wrong");
	AST_STRAP: assert property (@(posedge clk_sys) disable iff (!rst_b)
		strap_cnt_q == 2'h2 && !wr_en |=> ir_mode == $past(ir_strap_s))
		else $error("Strap not loaded");
	AST_DTR: assert property (@(posedge clk_sys) disable iff (!rst_b)
		##1 dtr_n == !$past(mcr_q[ucpd_pkg::MCR_DTR]))
		else $error("DTR polarity wrong");
endmodule : ucpd_top

// *** test/ucpd_line_model.sv ***
// Far-side line transceiver model driving the serial receive pin
`timescale 1ns/10ps
module ucpd_line_model (
	input  wire logic clk_sys,
	input  wire logic ir_mode,
	input  wire logic brk,
	input  wire logic pulse,
	output logic      rx_pin
);
	// Idle level follows the mode; only a commanded break or pulse leaves it
	always_ff @(posedge clk_sys)
	begin
		rx_pin <= ir_mode ? pulse : ~brk;
	end
endmodule : ucpd_line_model

// *** test/testbench.sv ***
// Self-checking bench for the UART pin and PC decode block
`timescale 1ns/10ps
`define CHK(g, e) check(32'({g}), 32'({e}))
module testbench;
	logic        clk_sys, rst_b, psel, penable, pwrite, pready, pslverr;
	logic [7:0]  paddr;
	logic [31:0] pwdata, prdata, v;
	logic [9:0]  host_addr;
	logic [2:0]  sel;
	logic [3:0]  core_int, m;
	logic        aen_n, pcsel_n, bstyle, com_select, printer1_decode_n_n, printer2_decode_n_n, baud_n;
	logic        baud_tick, rclk_pin, rx_clk_tick, tx_core_bit, tx_busy;
	logic        rx_room, tx_hold, rx_core_bit, tx_pin, rx_pin, ir_strap;
	logic        rts_n, cts_n, dtr_n, dsr_n, cd_n, ri_n, ir_mode, brk, pulse;
	logic [1:0]  ln;
	ucpd_pkg::ucpd_irq_s isa_irq;
	int          n_fail, total_checks;

	ucpd_top DUT (.clk_sys(clk_sys), .rst_b(rst_b), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr),
		.host_addr(host_addr), .address_enable_n(aen_n),
		.port_select_1(sel[2]), .port_select_2(sel[1]),
		.port_select_3(sel[0]), .pc_decode_select_n(pcsel_n),
		.bus_style_select(bstyle), .isa_irq(isa_irq),
		.com_select(com_select), .printer1_decode_n(printer1_decode_n_n),
		.printer2_decode_n(printer2_decode_n_n), .baud_gen_clock_out_n(baud_n),
		.baud_tick(baud_tick), .rclk_pin(rclk_pin),
		.rx_clk_tick(rx_clk_tick), .core_int_pending(core_int),
		.tx_core_bit(tx_core_bit), .tx_busy(tx_busy), .rx_room(rx_room),
		.tx_hold(tx_hold), .rx_core_bit(rx_core_bit), .tx_pin(tx_pin),
		.rx_pin(rx_pin), .infrared_enable_pin(ir_strap), .rts_n(rts_n),
		.cts_n(cts_n), .dtr_n(dtr_n), .dsr_n(dsr_n), .cd_n(cd_n),
		.ri_n(ri_n));

	ucpd_line_model line (.clk_sys(clk_sys), .ir_mode(ir_mode), .brk(brk),
		.pulse(pulse), .rx_pin(rx_pin));

	// Clock generation
	initial
	begin
		clk_sys = 1'b0;
		forever #4 clk_sys = ~clk_sys;
	end

	task automatic check(input logic [31:0] g, input logic [31:0] e);
		total_checks++;
		if (g !== e)
		begin
			n_fail++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
		end
	endtask : check

	task automatic tally_and_finish;
		$display("checks=%0d mismatches=%0d", total_checks, n_fail);
		if (n_fail == 0 && total_checks > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask : tally_and_finish

	// One APB transfer; an idle edge first so back-to-back calls never
	// assign psel twice in one time step
	task automatic apb(input logic wr, input logic [7:0] a,
		input logic [31:0] d, output logic [31:0] r, output logic err);
		int n;
		n = 0;
		@(posedge clk_sys);
		psel    <= 1'b1;
		pwrite  <= wr;
		paddr   <= a;
		pwdata  <= d;
		@(posedge clk_sys);
		penable <= 1'b1;
		// Access phase ends at the rising edge that sees pready high
		do
		begin
			@(posedge clk_sys);
			n++;
		end
		while (pready !== 1'b1 && n < 50);
		r   = prdata;
		err = pslverr;
		psel    <= 1'b0;
		penable <= 1'b0;
		if (n >= 50)
		begin
			n_fail++;
			tally_and_finish();
		end
	endtask : apb

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] r;
		logic        e;
		apb(1'b1, a, d, r, e);
	endtask : wr

	task automatic rd(input logic [7:0] a, output logic [31:0] r);
		logic e;
		apb(1'b0, a, 32'h0, r, e);
	endtask : rd

	// Pins need two sync stages plus the output register
	task automatic settle;
		repeat (5) @(posedge clk_sys);
		@(negedge clk_sys);
	endtask : settle

	// Watchdog, far beyond the expected run length
	initial
	begin
		repeat (20000) @(posedge clk_sys);
		n_fail++;
		tally_and_finish();
	end

	initial
	begin
		logic e;
		void'($urandom(61666));
		{rst_b, psel, penable, pwrite, paddr, pwdata, host_addr} = '0;
		{sel, core_int, baud_tick, rclk_pin, tx_busy, ir_strap} = '0;
		{ir_mode, brk, pulse, pcsel_n, cts_n} = 5'h03;
		{aen_n, bstyle, tx_core_bit, rx_room, dsr_n, cd_n, ri_n} = 7'h7F;
		n_fail = 0;
		total_checks = 0;
		repeat (2) @(posedge clk_sys);
		rst_b <= 1'b1;
		settle();
		`CHK({dtr_n, rts_n, tx_pin, rx_core_bit}, 4'hF);
		apb(1'b0, 8'h20, 32'h0, v, e);
		`CHK(e, 1'b1);
		`CHK(v, 32'h0);
		// Modem inputs, then auto CTS holding the transmitter
		for (int i = 0; i < 6; i++)
		begin
			if (i == 3)
				wr(ucpd_pkg::OFS_ENH_FEATURE, 32'h80);
			m = 4'($urandom);
			{cts_n, ri_n, cd_n, dsr_n} <= ~m;
			settle();
			rd(ucpd_pkg::OFS_PIN_STATUS, v);
			`CHK(v[3:0], m);
			`CHK(tx_hold, (i >= 3) && !m[3]);
		end
		for (int k = 0; k < 4; k++)
		begin
			wr(ucpd_pkg::OFS_MODEM_CTRL, 32'(k));
			settle();
			`CHK({rts_n, dtr_n}, ~2'(k));
		end
		// Auto RTS follows receive room once software asserts RTS
		wr(ucpd_pkg::OFS_ENH_FEATURE, 32'h40);
		wr(ucpd_pkg::OFS_MODEM_CTRL, 32'h02);
		rx_room <= 1'b0;
		settle();
		`CHK(rts_n, 1'b1);
		@(posedge clk_sys);
		rx_room <= 1'b1;
		settle();
		`CHK(rts_n, 1'b0);
		wr(ucpd_pkg::OFS_MODEM_CTRL, 32'h00);
		settle();
		`CHK(rts_n, 1'b1);
		// RS-485 direction overrides auto RTS
		wr(ucpd_pkg::OFS_EXTRA_FEAT, 32'h24);
		tx_busy <= 1'b1;
		settle();
		`CHK(rts_n, 1'b0);
		@(posedge clk_sys);
		tx_busy <= 1'b0;
		settle();
		`CHK(rts_n, 1'b1);
		wr(ucpd_pkg::OFS_EXTRA_FEAT, 32'h00);
		// Infrared by software: inverted transmit, pulse decoder
		wr(ucpd_pkg::OFS_MODEM_CTRL, 32'h40);
		ir_mode <= 1'b1;
		for (int i = 0; i < 4; i++)
		begin
			@(posedge clk_sys);
			tx_core_bit <= 1'($urandom);
			settle();
			`CHK(tx_pin, ~tx_core_bit);
		end
		`CHK(rx_core_bit, 1'b1);
		@(posedge clk_sys);
		pulse <= 1'b1;
		@(posedge clk_sys);
		pulse <= 1'b0;
		settle();
		`CHK(rx_core_bit, 1'b0);
		repeat (25) @(posedge clk_sys);
		@(negedge clk_sys);
		`CHK(rx_core_bit, 1'b1);
		rd(ucpd_pkg::OFS_PIN_STATUS, v);
		`CHK(v[4], 1'b1);
		// Normal mode and a long break on the line
		wr(ucpd_pkg::OFS_MODEM_CTRL, 32'h00);
		ir_mode <= 1'b0;
		settle();
		`CHK(tx_pin, tx_core_bit);
		rd(ucpd_pkg::OFS_PIN_STATUS, v);
		`CHK(v[8], 1'b0);
		brk <= 1'b1;
		repeat (200) @(posedge clk_sys);
		brk <= 1'b0;
		rd(ucpd_pkg::OFS_PIN_STATUS, v);
		`CHK(v[8], 1'b1);
		wr(ucpd_pkg::OFS_PIN_STATUS, 32'h100);
		rd(ucpd_pkg::OFS_PIN_STATUS, v);
		`CHK(v[8], 1'b0);
		// Outside PC mode the tick comes from rclk rising edges only
		@(posedge clk_sys);
		rclk_pin <= 1'b1;
		repeat (3) @(posedge clk_sys);
		@(negedge clk_sys);
		`CHK(rx_clk_tick, 1'b1);
		// Baud tick reaches the receiver clock only in PC mode
		@(posedge clk_sys);
		baud_tick <= 1'b1;
		settle();
		`CHK({rx_clk_tick, baud_n}, 2'b00);
		@(posedge clk_sys);
		{pcsel_n, bstyle, aen_n} <= 3'h0;
		host_addr <= ucpd_pkg::PRINTER1_DECODE_N_BASE;
		settle();
		`CHK({rx_clk_tick, printer1_decode_n_n, printer2_decode_n_n, baud_n}, 4'b1010);
		@(posedge clk_sys);
		host_addr <= ucpd_pkg::PRINTER2_DECODE_N_BASE;
		baud_tick <= 1'b0;
		settle();
		`CHK({printer1_decode_n_n, printer2_decode_n_n}, 2'b10);
		rd(ucpd_pkg::OFS_PIN_STATUS, v);
		`CHK(v[5], 1'b1);
		wr(ucpd_pkg::OFS_MODEM_CTRL, 32'h08);
		wr(ucpd_pkg::OFS_INT_ENABLE, 32'h01);
		core_int <= 4'h1;
		// Every strap setting: address validation and IRQ line choice
		for (int s = 0; s < 8; s++)
		begin
			ln = ucpd_pkg::SEL_IRQ[s];
			aen_n <= 1'b1;
			sel <= 3'(s);
			host_addr <= ucpd_pkg::COM_BASE[ucpd_pkg::SEL_COM[s] + 2'h1];
			settle();
			@(posedge clk_sys);
			aen_n <= 1'b0;
			settle();
			`CHK(com_select, 1'b0);
			@(posedge clk_sys);
			aen_n <= 1'b1;
			host_addr <= ucpd_pkg::COM_BASE[ucpd_pkg::SEL_COM[s]];
			settle();
			@(posedge clk_sys);
			aen_n <= 1'b0;
			settle();
			`CHK(com_select, 1'b1);
			`CHK({isa_irq.oe, isa_irq.level[ln]}, {3'h1 << ln, 1'b1});
		end
		wr(ucpd_pkg::OFS_MODEM_CTRL, 32'h00);
		settle();
		`CHK(isa_irq.oe, 3'h0);
		// Infrared strap taken at reset release, then software rules
		@(posedge clk_sys);
		ir_strap <= 1'b1;
		rst_b <= 1'b0;
		repeat (2) @(posedge clk_sys);
		rst_b <= 1'b1;
		settle();
		rd(ucpd_pkg::OFS_PIN_STATUS, v);
		`CHK({v[4], tx_pin}, {1'b1, ~tx_core_bit});
		wr(ucpd_pkg::OFS_MODEM_CTRL, 32'h00);
		rd(ucpd_pkg::OFS_PIN_STATUS, v);
		`CHK(v[4], 1'b0);
		tally_and_finish();
	end
endmodule : testbench
